// ===== uart_int_status_fifo_ctrl.sv
/*
  Interrupt prioritisation, identification and FIFO control for eight
  serial ports sharing one interrupt request. Registers sit behind a plain
  strobe port with read data one cycle after the read strobe.
  Assumes event inputs are one-cycle pulses on core_clk from the port logic.
*/
`timescale 1ns/100ps
module uart_int_status_fifo_ctrl
(
  // Clock and reset
  input  wire logic                                  core_clk,
  input  wire logic                                  resetn,
  // Register port
  input  wire logic [uisfc_pkg::ADDR_W-1:0]          reg_addr,
  input  wire logic [7:0]                            reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output logic      [7:0]                            reg_rdata,
  // Interrupt events from the ports
  input  wire logic [uisfc_pkg::NPORT-1:0]           evt_line_status,
  input  wire logic [uisfc_pkg::NPORT-1:0]           evt_rx_ready,
  input  wire logic [uisfc_pkg::NPORT-1:0]           evt_rx_timeout,
  input  wire logic [uisfc_pkg::NPORT-1:0]           evt_thr_empty,
  input  wire logic [uisfc_pkg::NPORT-1:0]           evt_modem_status,
  input  wire logic [uisfc_pkg::NPORT-1:0]           evt_xoff,
  input  wire logic [uisfc_pkg::NPORT-1:0]           evt_cts_rts,
  input  wire logic [uisfc_pkg::NPORT-1:0][6:0]      tx_fifo_count,
  // FIFO control to the ports
  output logic      [uisfc_pkg::NPORT-1:0]           fifo_enable,
  output logic      [uisfc_pkg::NPORT-1:0]           rx_flush,
  output logic      [uisfc_pkg::NPORT-1:0]           tx_flush,
  output logic      [uisfc_pkg::NPORT-1:0]           dma_mode,
  output logic      [uisfc_pkg::NPORT-1:0][1:0]      rx_trig_sel,
  // Shared interrupt
  output logic                                       shared_interrupt_request_n,
  output logic      [uisfc_pkg::PORT_W-1:0]          irq_port
);

  typedef struct packed {
    logic [uisfc_pkg::NPORT-1:0][uisfc_pkg::NSRC-1:0] pend;
    logic [uisfc_pkg::NPORT-1:0][2:0]                 cur_src;
    logic [uisfc_pkg::NPORT-1:0]                      cur_vld;
    logic [uisfc_pkg::NPORT-1:0][7:0]                 interrupt_enable;
    logic [uisfc_pkg::NPORT-1:0]                      unlock;
    logic [uisfc_pkg::NPORT-1:0]                      gate;
    logic [uisfc_pkg::NPORT-1:0]                      fen;
    logic [uisfc_pkg::NPORT-1:0]                      dma;
    logic [uisfc_pkg::NPORT-1:0][1:0]                 txtrig;
    logic [uisfc_pkg::NPORT-1:0][1:0]                 rxtrig;
    logic [uisfc_pkg::NPORT-1:0]                      tx_below;
    logic [uisfc_pkg::NPORT-1:0]                      rxfl;
    logic [uisfc_pkg::NPORT-1:0]                      txfl;
    logic [7:0]                                       rdata;
  } uisfc_state_s;

  uisfc_state_s s_r;
  uisfc_state_s s_nxt;

  logic [uisfc_pkg::PORT_W-1:0]    a_port;
  logic [uisfc_pkg::REG_W-1:0]     a_reg;
  logic [uisfc_pkg::NPORT-1:0]     port_req;
  logic [uisfc_pkg::NPORT-1:0]     eff_vld;
  logic [uisfc_pkg::NPORT-1:0][2:0] eff_src;

  assign a_port = reg_addr[uisfc_pkg::ADDR_W-1:uisfc_pkg::REG_W];
  assign a_reg  = reg_addr[uisfc_pkg::REG_W-1:0];

  // Enabled sources, in priority order
  function automatic logic [uisfc_pkg::NSRC-1:0] en_mask(logic [7:0] ie);
    logic [uisfc_pkg::NSRC-1:0] m;
    m = '0;
    m[uisfc_pkg::SRC_LS]   = ie[uisfc_pkg::IE_LS];
    m[uisfc_pkg::SRC_RXD]  = ie[uisfc_pkg::IE_RXD];
    m[uisfc_pkg::SRC_RXTO] = ie[uisfc_pkg::IE_RXD];
    m[uisfc_pkg::SRC_THR]  = ie[uisfc_pkg::IE_THR];
    m[uisfc_pkg::SRC_MSR]  = ie[uisfc_pkg::IE_MSR];
    m[uisfc_pkg::SRC_XOFF] = ie[uisfc_pkg::IE_XOFF];
    m[uisfc_pkg::SRC_CTS]  = ie[uisfc_pkg::IE_RTS] | ie[uisfc_pkg::IE_CTS];
    return m;
  endfunction : en_mask

  function automatic logic [2:0] first_set(logic [uisfc_pkg::NSRC-1:0] v);
    logic [2:0] r;
    r = '0;
    for (int i = uisfc_pkg::NSRC - 1; i >= 0; i--)
    begin
      if (v[i])
        r = i[2:0];
    end
    return r;
  endfunction : first_set

  function automatic logic [5:0] src_code(logic [2:0] src);
    logic [5:0] c;
    c = uisfc_pkg::CODE_MSR;
    unique case (src)
      uisfc_pkg::SRC_LS:   c = uisfc_pkg::CODE_LS;
      uisfc_pkg::SRC_RXD:  c = uisfc_pkg::CODE_RXD;
      uisfc_pkg::SRC_RXTO: c = uisfc_pkg::CODE_RXTO;
      uisfc_pkg::SRC_THR:  c = uisfc_pkg::CODE_THR;
      uisfc_pkg::SRC_MSR:  c = uisfc_pkg::CODE_MSR;
      uisfc_pkg::SRC_XOFF: c = uisfc_pkg::CODE_XOFF;
      uisfc_pkg::SRC_CTS:  c = uisfc_pkg::CODE_CTS;
      default:             c = uisfc_pkg::CODE_MSR;
    endcase
    return c;
  endfunction : src_code

  function automatic logic [7:0] ident_val
    (logic vld, logic [2:0] src, logic fen, logic unlk);
    logic [5:0] c;
    c = vld ? src_code(src) : uisfc_pkg::CODE_NONE;
    if (!unlk)
      c[5:4] = 2'h0;
    if (!fen)
      c[uisfc_pkg::ID_TO_BIT] = 1'b0;
    return {(fen ? uisfc_pkg::ID_FIFO : 2'h0), c};
  endfunction : ident_val

  function automatic logic [6:0] tx_level(logic [1:0] sel);
    logic [6:0] l;
    unique case (sel)
      2'h1:    l = uisfc_pkg::TXLVL_1;
      2'h2:    l = uisfc_pkg::TXLVL_2;
      default: l = uisfc_pkg::TXLVL_0;
    endcase
    return l;
  endfunction : tx_level

  // Reported source: the latched one, else the best pending right now
  always_comb
  begin
    for (int p = 0; p < uisfc_pkg::NPORT; p++)
    begin
      eff_vld[p] = s_r.cur_vld[p] | (|(s_r.pend[p] & en_mask(s_r.interrupt_enable[p])));
      eff_src[p] = s_r.cur_vld[p] ? s_r.cur_src[p]
                                  : first_set(s_r.pend[p] & en_mask(s_r.interrupt_enable[p]));
      port_req[p] = eff_vld[p] & s_r.gate[p];
    end
  end

  always_comb
  begin
    logic [uisfc_pkg::NSRC-1:0] set;
    logic [uisfc_pkg::NSRC-1:0] clr;
    logic                       below;
    logic                       fen_new;
    set     = '0;
    clr     = '0;
    below   = 1'b0;
    fen_new = 1'b0;
    s_nxt       = s_r;
    s_nxt.rxfl  = '0;
    s_nxt.txfl  = '0;
    s_nxt.rdata = '0;
    for (int p = 0; p < uisfc_pkg::NPORT; p++)
    begin
      below = tx_fifo_count[p] < tx_level(s_r.txtrig[p]);
      s_nxt.tx_below[p] = below;
      set = '0;
      clr = '0;
      set[uisfc_pkg::SRC_LS]   = evt_line_status[p];
      set[uisfc_pkg::SRC_RXD]  = evt_rx_ready[p];
      set[uisfc_pkg::SRC_RXTO] = evt_rx_timeout[p];
      set[uisfc_pkg::SRC_THR]  = s_r.fen[p] ? (below & ~s_r.tx_below[p])
                                            : evt_thr_empty[p];
      set[uisfc_pkg::SRC_MSR]  = evt_modem_status[p];
      set[uisfc_pkg::SRC_XOFF] = evt_xoff[p];
      set[uisfc_pkg::SRC_CTS]  = evt_cts_rts[p];
      if (reg_rd && a_port == p[uisfc_pkg::PORT_W-1:0] &&
          a_reg == uisfc_pkg::REG_IDENT)
      begin
        s_nxt.rdata = ident_val(eff_vld[p], eff_src[p], s_r.fen[p],
                                s_r.unlock[p]);
        if (eff_vld[p])
          clr[eff_src[p]] = 1'b1;
        s_nxt.cur_vld[p] = 1'b0;
      end
      else if (!s_r.cur_vld[p] && eff_vld[p])
      begin
        // Freeze the reported source until it is read
        s_nxt.cur_vld[p] = 1'b1;
        s_nxt.cur_src[p] = eff_src[p];
      end
      // A new event wins over a read clear of the same source
      s_nxt.pend[p] = (s_r.pend[p] & ~clr) | set;
    end

    if (reg_wr)
    begin
      unique case (a_reg)
        uisfc_pkg::REG_IER:
        begin
          s_nxt.interrupt_enable[a_port][uisfc_pkg::IER_LOCK-1:0] =
            reg_wdata[uisfc_pkg::IER_LOCK-1:0];
          if (s_r.unlock[a_port])
            s_nxt.interrupt_enable[a_port][7:uisfc_pkg::IER_LOCK] =
              reg_wdata[7:uisfc_pkg::IER_LOCK];
        end
        uisfc_pkg::REG_EFR:
          s_nxt.unlock[a_port] = reg_wdata[uisfc_pkg::EFR_UNLK];
        uisfc_pkg::REG_GATE:
          s_nxt.gate[a_port] = reg_wdata[uisfc_pkg::GATE_BIT];
        uisfc_pkg::REG_FIFO:
        begin
          fen_new = reg_wdata[uisfc_pkg::FC_EN];
          s_nxt.fen[a_port] = fen_new;
          if (!fen_new || fen_new != s_r.fen[a_port])
          begin
            s_nxt.rxfl[a_port] = 1'b1;
            s_nxt.txfl[a_port] = 1'b1;
          end
          if (fen_new)
          begin
            if (reg_wdata[uisfc_pkg::FC_RXCLR])
              s_nxt.rxfl[a_port] = 1'b1;
            if (reg_wdata[uisfc_pkg::FC_TXCLR])
              s_nxt.txfl[a_port] = 1'b1;
            // Mode only; no DMA pins exist on this block
            s_nxt.dma[a_port] = reg_wdata[uisfc_pkg::FC_DMA];
            s_nxt.rxtrig[a_port] = reg_wdata[uisfc_pkg::FC_RXT +: 2];
            if (s_r.unlock[a_port])
              s_nxt.txtrig[a_port] = reg_wdata[uisfc_pkg::FC_TXT +: 2];
          end
        end
        default:
        begin
        end
      endcase
    end

    if (reg_rd)
    begin
      unique case (a_reg)
        uisfc_pkg::REG_IER:
          s_nxt.rdata = s_r.interrupt_enable[a_port];
        uisfc_pkg::REG_EFR:
          s_nxt.rdata = {3'h0, s_r.unlock[a_port], 4'h0};
        uisfc_pkg::REG_GATE:
          s_nxt.rdata = {4'h0, s_r.gate[a_port], 3'h0};
        uisfc_pkg::REG_FSTAT:
          s_nxt.rdata = {s_r.rxtrig[a_port], s_r.txtrig[a_port],
                         s_r.dma[a_port], 2'h0, s_r.fen[a_port]};
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  uisfc_rr_arb u_arb
  (
    .core_clk                   (core_clk),
    .resetn                     (resetn),
    .req                        (port_req),
    .shared_interrupt_request_n (shared_interrupt_request_n),
    .irq_port                   (irq_port)
  );

  assign reg_rdata   = s_r.rdata;
  assign fifo_enable = s_r.fen;
  assign rx_flush    = s_r.rxfl;
  assign tx_flush    = s_r.txfl;
  assign dma_mode    = s_r.dma;
  assign rx_trig_sel = s_r.rxtrig;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_fifo_wr;
    reg_wr && a_reg == uisfc_pkg::REG_FIFO;
  endsequence

  sequence s_fifo_off;
    s_fifo_wr ##0 !reg_wdata[uisfc_pkg::FC_EN];
  endsequence

  sequence s_ident_rd;
    reg_rd && a_reg == uisfc_pkg::REG_IDENT;
  endsequence

  property p_ier_lock;
    reg_wr && a_reg == uisfc_pkg::REG_IER && !s_r.unlock[a_port]
      |=> s_r.interrupt_enable[$past(a_port)][7:4] == $past(s_r.interrupt_enable[a_port][7:4]);
  endproperty
  a_ier_lock: assert property (p_ier_lock)
    else $error("locked enable bits changed");

  property p_idle_ident;
    s_ident_rd ##0 !eff_vld[a_port]
      |=> reg_rdata[0] && reg_rdata[5:1] == 5'h00;
  endproperty
  a_idle_ident: assert property (p_idle_ident)
    else $error("idle identification not bit0 one");

  property p_read_clears;
    s_ident_rd ##0 s_r.cur_vld[a_port] && !evt_line_status[a_port] &&
      s_r.cur_src[a_port] == uisfc_pkg::SRC_LS
      |=> !s_r.pend[$past(a_port)][uisfc_pkg::SRC_LS];
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("reported source not cleared by read");

  property p_hold_reported;
    s_r.cur_vld[0] &&
      !(reg_rd && a_reg == uisfc_pkg::REG_IDENT && a_port == 3'h0)
      |=> s_r.cur_vld[0] && $stable(s_r.cur_src[0]);
  endproperty
  a_hold_reported: assert property (p_hold_reported)
    else $error("reported source changed before read");

  property p_fifo_off_flush;
    s_fifo_off |=> rx_flush[$past(a_port)] && tx_flush[$past(a_port)]
                   ##1 rx_flush == '0;
  endproperty
  a_fifo_off_flush: assert property (p_fifo_off_flush)
    else $error("disabling FIFOs did not flush once");

  property p_fifo_off_ignore;
    s_fifo_off |=> $stable(dma_mode) && $stable(rx_trig_sel);
  endproperty
  a_fifo_off_ignore: assert property (p_fifo_off_ignore)
    else $error("FIFO control bits programmed without enable");

  property p_mode_switch;
    fifo_enable != $past(fifo_enable)
      |-> ((fifo_enable ^ $past(fifo_enable)) & ~(rx_flush & tx_flush))
          == '0;
  endproperty
  a_mode_switch: assert property (p_mode_switch)
    else $error("mode switch without flush");

  property p_txtrig_lock;
    s_fifo_wr ##0 !s_r.unlock[a_port]
      |=> s_r.txtrig[$past(a_port)] == $past(s_r.txtrig[a_port]);
  endproperty
  a_txtrig_lock: assert property (p_txtrig_lock)
    else $error("transmit trigger written while locked");

  property p_reset_state;
    disable iff (1'b0)
    !resetn |=> fifo_enable == '0 && dma_mode == '0 && rx_trig_sel == '0
                && shared_interrupt_request_n;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset did not clear FIFO control");

  property p_request_gate;
    !shared_interrupt_request_n |-> $past(s_r.gate[irq_port]);
  endproperty
  a_request_gate: assert property (p_request_gate)
    else $error("request raised by gated port");

endmodule : uart_int_status_fifo_ctrl

// ===== uart_int_status_fifo_ctrl_tb.sv
/*
  Self-checking bench for the interrupt status and FIFO control block.
  Assumes the host handler model and a 20 MHz core clock.
*/
`timescale 1ns/100ps
module uart_int_status_fifo_ctrl_tb;
  logic            core_clk = 0;
  logic            resetn = 0;
  logic [5:0]      reg_addr = '0;
  logic [7:0]      reg_wdata = '0;
  logic            reg_wr = 0;
  logic            reg_rd = 0;
  logic [7:0]      reg_rdata;
  logic [7:0]      evt [7] = '{default: '0};
  logic [7:0][6:0] tx_fifo_count = {8{7'h28}};
  logic [7:0]      fifo_enable, rx_flush, tx_flush, dma_mode;
  logic [7:0][1:0] rx_trig_sel;
  logic            shared_interrupt_request_n, seen;
  logic [2:0]      irq_port, sport;
  int              cmp_count = 0, bad_count = 0, rxc = 0, txc = 0;
  localparam logic [7:0] CODES [7] = '{8'h06, 8'h04, 8'h04, 8'h02,
                                       8'h00, 8'h10, 8'h20};

  uart_int_status_fifo_ctrl dut (.core_clk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .evt_line_status(evt[0]),
    .evt_rx_ready(evt[1]), .evt_rx_timeout(evt[2]), .evt_thr_empty(evt[3]),
    .evt_modem_status(evt[4]), .evt_xoff(evt[5]), .evt_cts_rts(evt[6]),
    .tx_fifo_count, .fifo_enable, .rx_flush, .tx_flush, .dma_mode,
    .rx_trig_sel, .shared_interrupt_request_n, .irq_port);
  uisfc_host_model host (.core_clk, .resetn, .shared_interrupt_request_n,
    .irq_port, .irq_seen(seen), .served_port(sport));

  always #25 core_clk = ~core_clk;
  // Flush pulses of port 0 are tallied to spot missing or extra ones
  always @(posedge core_clk)
  begin
    rxc += int'(rx_flush[0]);
    txc += int'(tx_flush[0]);
  end

  function automatic logic [5:0] ad(input int p, input logic [2:0] r);
    return {p[2:0], r};
  endfunction : ad

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask : wr

  task automatic rchk(input string n, input logic [5:0] a, logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 chk(n, reg_rdata, e);
  endtask : rchk

  task automatic pulse(input int s, input logic [7:0] m);
    @(posedge core_clk);
    evt[s] <= m;
    @(posedge core_clk);
    evt[s] <= '0;
    repeat (3) @(posedge core_clk);
  endtask : pulse

  task automatic wait_grant(input int p);
    int i;
    for (i = 0; i < 20 && !(seen === 1'b1 && sport === 3'(p)); i++)
      @(posedge core_clk);
    chk("grant", {5'h00, sport}, 8'(p));
    if (i == 20)
    begin
      bad_count++;
      stop_test();
    end
  endtask : wait_grant

  task automatic test_lock;
    wr(ad(5, uisfc_pkg::REG_IER), 8'h00);
    rchk("enable", ad(5, uisfc_pkg::REG_IER), 8'hF0);
    wr(ad(5, uisfc_pkg::REG_IER), 8'hFF);
    pulse(5, 8'h20);
    rchk("ident", ad(5, uisfc_pkg::REG_IDENT), 8'h00);
    $display("test_lock done");
  endtask : test_lock

  task automatic test_codes;
    for (int s = 0; s < 7; s++)
    begin
      pulse(s, 8'h01);
      wait_grant(0);
      rchk("code", ad(0, uisfc_pkg::REG_IDENT), CODES[s]);
      rchk("idle", ad(0, uisfc_pkg::REG_IDENT), 8'h01);
    end
    $display("test_codes done");
  endtask : test_codes

  task automatic test_order;
    pulse(4, 8'h01);
    pulse(0, 8'h01);
    pulse(3, 8'h01);
    rchk("held", ad(0, uisfc_pkg::REG_IDENT), 8'h00);
    rchk("top", ad(0, uisfc_pkg::REG_IDENT), 8'h06);
    rchk("lower", ad(0, uisfc_pkg::REG_IDENT), 8'h02);
    rchk("none", ad(0, uisfc_pkg::REG_IDENT), 8'h01);
    $display("test_order done");
  endtask : test_order

  task automatic test_rr;
    logic line_hi;
    pulse(4, 8'h08);
    wait_grant(3);
    rchk("p3", ad(3, uisfc_pkg::REG_IDENT), 8'h00);
    // Lowest index would win under fixed priority; rotation must pick 5
    pulse(4, 8'h24);
    wait_grant(5);
    rchk("p5", ad(5, uisfc_pkg::REG_IDENT), 8'h00);
    wait_grant(2);
    rchk("p2", ad(2, uisfc_pkg::REG_IDENT), 8'h00);
    repeat (4) @(posedge core_clk);
    pulse(0, 8'h10);
    line_hi = 1;
    repeat (8) @(posedge core_clk) line_hi &= shared_interrupt_request_n;
    chk("gate", {7'h00, line_hi}, 8'h01);
    wr(ad(4, uisfc_pkg::REG_GATE), 8'h08);
    wait_grant(4);
    rchk("p4", ad(4, uisfc_pkg::REG_IDENT), 8'h06);
    $display("test_rr done");
  endtask : test_rr

  task automatic fstat(input logic [7:0] e, input int r, t);
    repeat (3) @(posedge core_clk);
    chk("rx flushes", 8'(rxc), 8'(r));
    chk("tx flushes", 8'(txc), 8'(t));
    rchk("fstat", ad(0, uisfc_pkg::REG_FSTAT), e);
  endtask : fstat

  task automatic test_fifo;
    wr(ad(0, uisfc_pkg::REG_EFR), 8'h00);
    wr(ad(0, uisfc_pkg::REG_FIFO), 8'h01);
    fstat(8'h01, 1, 1);
    chk("fen", {7'h00, fifo_enable[0]}, 8'h01);
    wr(ad(0, uisfc_pkg::REG_FIFO), 8'h09);
    fstat(8'h09, 1, 1);
    wr(ad(0, uisfc_pkg::REG_FIFO), 8'hF3);
    fstat(8'hC1, 2, 1);
    wr(ad(0, uisfc_pkg::REG_FIFO), 8'h05);
    fstat(8'h01, 2, 2);
    wr(ad(0, uisfc_pkg::REG_EFR), 8'h10);
    wr(ad(0, uisfc_pkg::REG_FIFO), 8'h21);
    fstat(8'h21, 2, 2);
    rchk("fifo idle", ad(0, uisfc_pkg::REG_IDENT), 8'hC1);
    pulse(2, 8'h01);
    rchk("timeout", ad(0, uisfc_pkg::REG_IDENT), 8'hCC);
    tx_fifo_count[0] <= 7'h1F;
    repeat (3) @(posedge core_clk);
    rchk("tx level", ad(0, uisfc_pkg::REG_IDENT), 8'hC2);
    wr(ad(0, uisfc_pkg::REG_FIFO), 8'h0E);
    fstat(8'h20, 3, 3);
    rchk("off idle", ad(0, uisfc_pkg::REG_IDENT), 8'h01);
    $display("test_fifo done");
  endtask : test_fifo

  initial
  begin
    repeat (5) @(posedge core_clk);
    resetn <= 1;
    rchk("reset ident", ad(0, uisfc_pkg::REG_IDENT), 8'h01);
    rchk("reset fstat", ad(0, uisfc_pkg::REG_FSTAT), 8'h00);
    chk("reset line", {7'h00, shared_interrupt_request_n}, 8'h01);
    rchk("unmapped", ad(0, 3'h7), 8'h00);
    for (int p = 0; p < 8; p++)
    begin
      wr(ad(p, uisfc_pkg::REG_EFR), 8'h10);
      wr(ad(p, uisfc_pkg::REG_IER), 8'hFF);
      wr(ad(p, uisfc_pkg::REG_GATE), (p == 4) ? 8'h00 : 8'h08);
    end
    test_codes();
    test_order();
    test_rr();
    wr(ad(5, uisfc_pkg::REG_EFR), 8'h00);
    test_lock();
    test_fifo();
    stop_test();
  end
endmodule : uart_int_status_fifo_ctrl_tb

// ===== uisfc_host_model.sv
/*
  Host-side interrupt handler model: notes which port holds the line.
  Assumes the shared request is an active-low level on core_clk.
*/
`timescale 1ns/100ps
module uisfc_host_model
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Shared interrupt
  input  wire logic       shared_interrupt_request_n,
  input  wire logic [2:0] irq_port,
  // Handler view
  output logic            irq_seen,
  output logic [2:0]      served_port
);
  // Vector is only trusted while the line is held low
  always_ff @(posedge core_clk)
  begin
    irq_seen <= resetn && !shared_interrupt_request_n;
    if (!shared_interrupt_request_n)
      served_port <= irq_port;
  end
endmodule : uisfc_host_model

// ===== uisfc_pkg.sv
/*
  Constants shared by the interrupt status and FIFO control block and its
  round-robin arbiter: register map, field positions, codes and levels.
  Assumes a single core_clk domain and a synchronous active-low reset.
*/
package uisfc_pkg;

  localparam int NPORT  = 8;
  localparam int PORT_W = 3;
  localparam int REG_W  = 3;
  localparam int ADDR_W = PORT_W + REG_W;
  localparam int NSRC   = 7;
  localparam int CNT_W  = 7;

  // Per-port register index, address = {port, index}
  localparam logic [REG_W-1:0] REG_IDENT  = 3'h0;
  localparam logic [REG_W-1:0] REG_FIFO   = 3'h1;
  localparam logic [REG_W-1:0] REG_IER    = 3'h2;
  localparam logic [REG_W-1:0] REG_EFR    = 3'h3;
  localparam logic [REG_W-1:0] REG_GATE   = 3'h4;
  localparam logic [REG_W-1:0] REG_FSTAT  = 3'h5;

  // FIFO control fields, then the unlock, gate and enable-lock bit positions
  localparam int FC_EN    = 0;
  localparam int FC_RXCLR = 1;
  localparam int FC_TXCLR = 2;
  localparam int FC_DMA   = 3;
  localparam int FC_TXT   = 4;
  localparam int FC_RXT   = 6;
  localparam int EFR_UNLK = 4;
  localparam int GATE_BIT = 3;
  localparam int IER_LOCK = 4;

  // Interrupt-enable bit positions; receive timeout shares IE_RXD, and IE_RTS or IE_CTS enables SRC_CTS
  localparam int IE_RXD  = 0;
  localparam int IE_THR  = 1;
  localparam int IE_LS   = 2;
  localparam int IE_MSR  = 3;
  localparam int IE_XOFF = 5;
  localparam int IE_RTS  = 6;
  localparam int IE_CTS  = 7;

  // Source index is priority order, lowest index wins
  localparam logic [2:0] SRC_LS   = 3'h0;
  localparam logic [2:0] SRC_RXD  = 3'h1;
  localparam logic [2:0] SRC_RXTO = 3'h2;
  localparam logic [2:0] SRC_THR  = 3'h3;
  localparam logic [2:0] SRC_MSR  = 3'h4;
  localparam logic [2:0] SRC_XOFF = 3'h5;
  localparam logic [2:0] SRC_CTS  = 3'h6;

  localparam logic [5:0] CODE_LS   = 6'h06;
  localparam logic [5:0] CODE_RXD  = 6'h04;
  localparam logic [5:0] CODE_RXTO = 6'h0C;
  localparam logic [5:0] CODE_THR  = 6'h02;
  localparam logic [5:0] CODE_MSR  = 6'h00;
  localparam logic [5:0] CODE_XOFF = 6'h10;
  localparam logic [5:0] CODE_CTS  = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;
  localparam int         ID_TO_BIT = 3;
  localparam logic [1:0] ID_FIFO   = 2'h3;
  localparam logic [7:0] ID_RESET  = 8'h01;

  // Transmit trigger levels; code 11 is unlisted and falls back to 8
  localparam logic [CNT_W-1:0] TXLVL_0 = 7'h08;
  localparam logic [CNT_W-1:0] TXLVL_1 = 7'h10;
  localparam logic [CNT_W-1:0] TXLVL_2 = 7'h20;

endpackage : uisfc_pkg

// ===== uisfc_rr_arb.sv
/*
  Round-robin arbiter for the shared interrupt request line.
  Assumes requests are levels on core_clk that drop once a port is serviced.
*/
`timescale 1ns/100ps
module uisfc_rr_arb
(
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  // Port requests
  input  wire logic [uisfc_pkg::NPORT-1:0]   req,
  // Shared request and served port
  output logic                               shared_interrupt_request_n,
  output logic [uisfc_pkg::PORT_W-1:0]       irq_port
);

  typedef struct packed {
    logic [uisfc_pkg::PORT_W-1:0] grant;
    logic                         vld;
  } uisfc_arb_s;

  uisfc_arb_s s_r;
  uisfc_arb_s s_nxt;
  logic [uisfc_pkg::PORT_W:0] cand;

  // Search starts just after the last served port
  function automatic logic [uisfc_pkg::PORT_W:0] next_grant
    (logic [uisfc_pkg::NPORT-1:0] r, logic [uisfc_pkg::PORT_W-1:0] last);
    logic [uisfc_pkg::PORT_W:0]   res;
    logic [uisfc_pkg::PORT_W-1:0] idx;
    res = '0;
    for (int i = uisfc_pkg::NPORT; i >= 1; i--)
    begin
      idx = last + i[uisfc_pkg::PORT_W-1:0];
      if (r[idx])
        res = {1'b1, idx};
    end
    return res;
  endfunction : next_grant

  always_comb
  begin
    s_nxt = s_r;
    cand  = next_grant(req, s_r.grant);
    // Hold the grant until the port has been serviced
    if (!(s_r.vld && req[s_r.grant]))
    begin
      s_nxt.vld = cand[uisfc_pkg::PORT_W];
      // Last served port survives idle gaps so rotation continues
      if (cand[uisfc_pkg::PORT_W])
        s_nxt.grant = cand[uisfc_pkg::PORT_W-1:0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign shared_interrupt_request_n = ~s_r.vld;
  assign irq_port                   = s_r.grant;

endmodule : uisfc_rr_arb
